// ==== bss_top.sv ====
// Purpose: Backplane slave signalling: data transfer, interrupt, fail and reset
// Assumes: Address decode done elsewhere on i_clock; open-drain lines resolved outside
// Notes:   Longword data cycles are not answered; this slave is 16 bits wide
`timescale 1ns/1ns
module bss_top (
    input  wire logic                             i_clock,
    input  wire logic                             i_rst_n,
    input  wire logic                             i_as_n,
    input  wire logic                             i_ds0_n,
    input  wire logic                             i_ds1_n,
    input  wire logic                             i_write_n,
    input  wire logic                             i_lword_n,
    input  wire logic                             i_iack_n,
    input  wire logic                             i_iackin_n,
    input  wire logic                             i_sysreset_n,
    input  wire logic                             i_sysfail_n,
    input  wire logic [bss_pkg::LEVEL_W-1:0]      i_ack_level,
    input  wire logic [bss_pkg::DATA_W-1:0]       i_data,
    output logic      [bss_pkg::DATA_W-1:0]       o_data,
    output logic                                  o_data_oe,
    output logic                                  o_dtack_oe,
    output logic                                  o_iackout_n,
    output logic      [bss_pkg::IRQ_LINES-1:0]    o_irq_oe,
    output logic                                  o_sysfail_oe,
    input  wire logic                             i_board_sel,
    output logic                                  o_rd_req,
    input  wire logic                             i_rd_valid,
    input  wire logic [bss_pkg::DATA_W-1:0]       i_rd_data,
    output logic                                  o_wr_strobe,
    output logic      [bss_pkg::DATA_W-1:0]       o_wr_data,
    output logic      [1:0]                       o_wr_lanes,
    input  wire logic                             i_irq_req,
    input  wire logic [bss_pkg::LEVEL_W-1:0]      i_irq_level,
    input  wire logic [bss_pkg::VEC_W-1:0]        i_vector,
    input  wire logic                             i_fail_req,
    output logic                                  o_fail_seen,
    output logic                                  o_in_reset
);

    // Either data strobe low means a transfer phase is active
    function automatic logic bss_strobe(input logic [bss_pkg::SYNC_W-1:0] v);
        return !v[bss_pkg::POS_DS0] || !v[bss_pkg::POS_DS1];
    endfunction

    logic [bss_pkg::SYNC_W-1:0]    sync_a_ff;
    logic [bss_pkg::SYNC_W-1:0]    sync_b_ff;
    logic                          blk_rst;
    logic                          strobe;
    logic                          cyc_start;
    logic                          iack_cyc;
    logic                          iack_ours;
    logic                          wr_n_s;
    bss_pkg::bss_state_type        state_ff;
    bss_pkg::bss_state_type        nxt_state;
    logic                          cyc_write_ff;
    logic                          irq_pend_ff;
    logic [bss_pkg::LEVEL_W-1:0]   irq_level_ff;
    logic [bss_pkg::DATA_W-1:0]    data_ff;
    logic                          data_oe_ff;
    logic                          dtack_ff;
    logic                          iackout_n_ff;
    logic [bss_pkg::IRQ_LINES-1:0] irq_oe_ff;
    logic                          sysfail_oe_ff;
    logic                          fail_seen_ff;
    logic                          rd_req_ff;
    logic                          wr_strobe_ff;
    logic [bss_pkg::DATA_W-1:0]    wr_data_ff;
    logic [1:0]                    wr_lanes_ff;

    // Two-stage synchroniser for every backplane input
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            sync_a_ff <= bss_pkg::SYNC_RST;
            sync_b_ff <= bss_pkg::SYNC_RST;
        end else begin
            sync_a_ff <= {i_data, i_ack_level, i_sysfail_n, i_sysreset_n, i_iackin_n, i_iack_n,
                          i_lword_n, i_write_n, i_ds1_n, i_ds0_n, i_as_n};
            sync_b_ff <= sync_a_ff;
        end
    end

    // Backplane reset joins local reset
    assign blk_rst   = !i_rst_n || !sync_b_ff[bss_pkg::POS_SYSRST]; // RULE14
    assign strobe    = bss_strobe(sync_b_ff); // RULE2 RULE3
    assign wr_n_s    = sync_b_ff[bss_pkg::POS_WRITE];
    assign iack_cyc  = !sync_b_ff[bss_pkg::POS_IACK] && !sync_b_ff[bss_pkg::POS_IACKIN]; // RULE10
    assign iack_ours = irq_pend_ff && (sync_b_ff[bss_pkg::POS_LEVEL +: bss_pkg::LEVEL_W] == irq_level_ff);
    // Longword data cycles fall outside this 16-bit slave; acknowledge cycles do not test longword
    assign cyc_start = strobe && !sync_b_ff[bss_pkg::POS_AS] &&
                       (iack_cyc || (sync_b_ff[bss_pkg::POS_IACK] && i_board_sel &&
                                     sync_b_ff[bss_pkg::POS_LWORD]));

    // Cycle sequencing
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            bss_pkg::ST_IDLE: begin
                if (cyc_start) begin
                    if (iack_cyc) begin
                        nxt_state = iack_ours ? bss_pkg::ST_RD_SETTLE : bss_pkg::ST_PASS;
                    end else if (wr_n_s) begin
                        nxt_state = bss_pkg::ST_RD_WAIT; // RULE7
                    end else begin
                        nxt_state = bss_pkg::ST_WR_TAKE; // RULE7
                    end
                end
            end
            bss_pkg::ST_RD_WAIT: begin
                if (!strobe) begin
                    nxt_state = bss_pkg::ST_IDLE; // Master gave up
                end else if (i_rd_valid) begin
                    nxt_state = bss_pkg::ST_RD_SETTLE;
                end
            end
            bss_pkg::ST_RD_SETTLE: nxt_state = bss_pkg::ST_ACK; // RULE4
            bss_pkg::ST_WR_TAKE:   nxt_state = bss_pkg::ST_ACK; // RULE5
            bss_pkg::ST_ACK: begin
                if (!strobe) begin
                    nxt_state = bss_pkg::ST_IDLE; // RULE15
                end
            end
            bss_pkg::ST_PASS: begin
                if (sync_b_ff[bss_pkg::POS_AS]) begin
                    nxt_state = bss_pkg::ST_IDLE;
                end
            end
            default: nxt_state = bss_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_clock) begin
        if (blk_rst) begin
            state_ff <= bss_pkg::ST_IDLE; // RULE14
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Direction of the current cycle
    always_ff @(posedge i_clock) begin
        if (blk_rst) begin
            cyc_write_ff <= 1'b0;
        end else if (state_ff == bss_pkg::ST_IDLE && cyc_start) begin
            cyc_write_ff <= !iack_cyc && !wr_n_s;
        end
    end

    // Read data and vector onto the bus, released after handshake
    always_ff @(posedge i_clock) begin
        if (blk_rst) begin
            data_ff    <= bss_pkg::DATA_RST;
            data_oe_ff <= 1'b0;
        end else if (state_ff == bss_pkg::ST_IDLE && cyc_start && iack_cyc && iack_ours) begin
            data_ff    <= {bss_pkg::VEC_PAD, i_vector};
            data_oe_ff <= 1'b1; // RULE6
        end else if (state_ff == bss_pkg::ST_RD_WAIT && strobe && i_rd_valid) begin
            data_ff    <= i_rd_data;
            data_oe_ff <= 1'b1; // RULE6
        end else if (nxt_state == bss_pkg::ST_IDLE) begin
            data_oe_ff <= 1'b0;
        end
    end

    // Acknowledge after data settled or taken, held until strobes clear
    always_ff @(posedge i_clock) begin
        if (blk_rst) begin
            dtack_ff <= 1'b0;
        end else begin
            dtack_ff <= (nxt_state == bss_pkg::ST_ACK); // RULE4 RULE5 RULE15
        end
    end

    // Local read request and write capture
    always_ff @(posedge i_clock) begin
        if (blk_rst) begin
            rd_req_ff    <= 1'b0;
            wr_strobe_ff <= 1'b0;
            wr_data_ff   <= bss_pkg::DATA_RST;
            wr_lanes_ff  <= 2'h0;
        end else begin
            rd_req_ff    <= (state_ff == bss_pkg::ST_IDLE) && (nxt_state == bss_pkg::ST_RD_WAIT);
            wr_strobe_ff <= (state_ff == bss_pkg::ST_IDLE) && (nxt_state == bss_pkg::ST_WR_TAKE); // RULE5
            if (state_ff == bss_pkg::ST_IDLE && nxt_state == bss_pkg::ST_WR_TAKE) begin
                wr_data_ff  <= sync_b_ff[bss_pkg::POS_DATA +: bss_pkg::DATA_W]; // RULE6
                wr_lanes_ff <= {!sync_b_ff[bss_pkg::POS_DS1], !sync_b_ff[bss_pkg::POS_DS0]}; // RULE2 RULE3
            end
        end
    end

    // Interrupt pending; a new request wins over the acknowledge clear
    always_ff @(posedge i_clock) begin
        if (blk_rst) begin
            irq_pend_ff  <= 1'b0;
            irq_level_ff <= bss_pkg::LEVEL_RST;
        end else if (i_irq_req && i_irq_level != bss_pkg::LEVEL_RST) begin
            irq_pend_ff  <= 1'b1;
            irq_level_ff <= i_irq_level;
        end else if (state_ff == bss_pkg::ST_IDLE && cyc_start && iack_cyc && iack_ours) begin
            irq_pend_ff  <= 1'b0;
        end
    end

    // Level decode onto the seven request lines, acknowledge chain pass-on
    always_ff @(posedge i_clock) begin
        if (blk_rst) begin
            irq_oe_ff    <= bss_pkg::IRQ_RST;
            iackout_n_ff <= 1'b1;
        end else begin
            for (int k = 1; k <= bss_pkg::IRQ_LINES; k++) begin
                irq_oe_ff[k-1] <= irq_pend_ff && (irq_level_ff == k[bss_pkg::LEVEL_W-1:0]); // RULE9
            end
            iackout_n_ff <= (nxt_state != bss_pkg::ST_PASS); // RULE10
        end
    end

    // System fail drive and observation
    always_ff @(posedge i_clock) begin
        if (blk_rst) begin
            sysfail_oe_ff <= 1'b0;
            fail_seen_ff  <= 1'b0;
        end else begin
            sysfail_oe_ff <= i_fail_req; // RULE13
            fail_seen_ff  <= !sync_b_ff[bss_pkg::POS_SYSFL]; // RULE13
        end
    end

    // The reserved backplane line has no port here
    assign o_data       = data_ff; // RULE11
    assign o_data_oe    = data_oe_ff;
    assign o_dtack_oe   = dtack_ff;
    assign o_iackout_n  = iackout_n_ff;
    assign o_irq_oe     = irq_oe_ff;
    assign o_sysfail_oe = sysfail_oe_ff;
    assign o_fail_seen  = fail_seen_ff;
    assign o_rd_req     = rd_req_ff;
    assign o_wr_strobe  = wr_strobe_ff;
    assign o_wr_data    = wr_data_ff;
    assign o_wr_lanes   = wr_lanes_ff;
    assign o_in_reset   = blk_rst;

    // Checks
    a_read_data_first: assert property (@(posedge i_clock) disable iff (blk_rst) // RULE4
        $rose(dtack_ff) && !cyc_write_ff |-> $past(data_oe_ff) && data_oe_ff)
        else $error("read acknowledge before data on bus");

    a_write_data_taken: assert property (@(posedge i_clock) disable iff (blk_rst) // RULE5
        $rose(dtack_ff) && cyc_write_ff |-> $past(wr_strobe_ff))
        else $error("write acknowledge before data taken");

    a_bus_drive_dir: assert property (@(posedge i_clock) disable iff (blk_rst) // RULE6
        data_oe_ff |-> !cyc_write_ff)
        else $error("data bus driven during write");

    a_write_decode: assert property (@(posedge i_clock) disable iff (blk_rst) // RULE7
        rd_req_ff |-> $past(wr_n_s) ##[1:1000] (dtack_ff || !strobe))
        else $error("read started on low write line");

    a_irq_one_level: assert property (@(posedge i_clock) disable iff (blk_rst) // RULE9
        $onehot0(irq_oe_ff))
        else $error("interrupt level drive wrong");

    a_irq_top_level: assert property (@(posedge i_clock) disable iff (blk_rst) // RULE9
        irq_pend_ff && irq_level_ff == 3'h7 |=> irq_oe_ff[6])
        else $error("level seven request not driven");

    a_fail_follow: assert property (@(posedge i_clock) disable iff (blk_rst) // RULE13
        i_fail_req |=> sysfail_oe_ff)
        else $error("system fail not driven");

    a_sys_reset_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n) // RULE14
        !sync_b_ff[bss_pkg::POS_SYSRST] |=> state_ff == bss_pkg::ST_IDLE && !dtack_ff && !data_oe_ff)
        else $error("module active during system reset");

    a_ack_hold: assert property (@(posedge i_clock) disable iff (blk_rst) // RULE15
        dtack_ff && strobe |=> dtack_ff)
        else $error("acknowledge dropped while strobe active");

    a_ack_release: assert property (@(posedge i_clock) disable iff (blk_rst) // RULE15
        dtack_ff && !strobe |=> !dtack_ff ##1 !dtack_ff)
        else $error("acknowledge kept after strobes released");

endmodule

// ==== bss_pkg.sv ====
// Purpose: Shared constants and types for the backplane slave signalling block
// Assumes: 16-bit slave on the backplane data transfer bus, one 100 MHz clock
// Notes:   Backplane strobes and lines arrive asynchronously and are synchronised
//
// Functional notes
// (RULE1) Requesters assert one of four bus requests
// (RULE2) Low data strobe marks low byte lane
// (RULE3) Second data strobe marks the data lines
// (RULE4) Read acknowledge falls only after data valid
// (RULE5) Write acknowledge falls only after data taken
// (RULE6) Sixteen bidirectional data lines, source drives
// (RULE7) Write line high reads, low writes
// (RULE8) Master asserts longword for 32-bit transfers
// (RULE9) Seven active-low request levels, seven highest
// (RULE10) Global acknowledge loops back into slot chain
// (RULE11) Reserved backplane line never driven nor read
// (RULE12) System clock runs constant sixteen megahertz
// (RULE13) Any module may assert system fail
// (RULE14) System reset low holds module in reset
// (RULE15) Acknowledge held until strobes released
package bss_pkg;

    localparam int unsigned DATA_W     = 16;
    localparam int unsigned VEC_W      = 8;
    localparam int unsigned IRQ_LINES  = 7;
    localparam int unsigned LEVEL_W    = 3;
    localparam int unsigned CTRL_W     = 9;
    localparam int unsigned SYNC_W     = CTRL_W + LEVEL_W + DATA_W;

    // Positions of the control, level and data lines inside the synchroniser vector
    localparam int unsigned POS_AS     = 0;
    localparam int unsigned POS_DS0    = 1;
    localparam int unsigned POS_DS1    = 2;
    localparam int unsigned POS_WRITE  = 3;
    localparam int unsigned POS_LWORD  = 4;
    localparam int unsigned POS_IACK   = 5;
    localparam int unsigned POS_IACKIN = 6;
    localparam int unsigned POS_SYSRST = 7;
    localparam int unsigned POS_SYSFL  = 8;
    localparam int unsigned POS_LEVEL  = CTRL_W;
    localparam int unsigned POS_DATA   = CTRL_W + LEVEL_W;

    // Reset values
    localparam logic [SYNC_W-1:0]    SYNC_RST  = {{DATA_W{1'b0}}, {LEVEL_W{1'b0}}, {CTRL_W{1'b1}}};
    localparam logic [DATA_W-1:0]    DATA_RST  = 16'h0000;
    localparam logic [LEVEL_W-1:0]   LEVEL_RST = 3'h0;
    localparam logic [IRQ_LINES-1:0] IRQ_RST   = 7'h00;
    localparam logic [VEC_W-1:0]     VEC_PAD   = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_WAIT,
        ST_RD_SETTLE,
        ST_WR_TAKE,
        ST_ACK,
        ST_PASS
    } bss_state_type;

endpackage

// ==== bss_master_model.sv ====
// Purpose: Behavioural backplane master for the slave signalling block
// Assumes: One 100 MHz clock; pins change just after rising edges
// Notes:   Released data lines show the inverse of the last value driven
`timescale 1ns/1ns
module bss_master_model (
    input  wire logic        i_clock,
    input  wire logic        i_dtack_oe,
    input  wire logic [15:0] i_bus,
    output logic             o_as_n,
    output logic             o_ds0_n,
    output logic             o_ds1_n,
    output logic             o_write_n,
    output logic             o_lword_n,
    output logic             o_iack_n,
    output logic             o_iackin_n,
    output logic [2:0]       o_level,
    output logic [3:0]       o_br_n,
    output logic             o_sysclk,
    output logic [15:0]      o_data
);
    // Slot 1 loops the global acknowledge into the chain
    assign o_iackin_n = o_iack_n;

    // Idle bus at time zero
    initial begin
        {o_as_n, o_ds0_n, o_ds1_n, o_write_n, o_lword_n, o_iack_n} = 6'h3f;
        o_level = 3'h0;
        o_br_n  = 4'hf;
        o_data  = 16'h0000;
    end

    // Backplane system clock, 62.5 ns average period in 1 ns steps
    initial begin
        o_sysclk = 1'b0;
        forever begin
            #31 o_sysclk = ~o_sysclk;
            #31 o_sysclk = ~o_sysclk;
            #31 o_sysclk = ~o_sysclk;
            #32 o_sysclk = ~o_sysclk;
        end
    end

    // One transfer: strobes held until acknowledge or 20 cycles, then released
    task automatic xfer(input logic wr, input logic [1:0] lanes, input logic lw, input logic ia,
                        input logic [2:0] lvl, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok, output logic held);
        int n;
        @(posedge i_clock);
        o_br_n    <= 4'he;
        o_write_n <= ~wr;
        o_lword_n <= ~lw;
        o_iack_n  <= ~ia;
        o_level   <= lvl;
        o_as_n    <= 1'b0;
        o_ds0_n   <= ~lanes[0];
        o_ds1_n   <= ~lanes[1];
        if (wr) o_data <= wd;
        ok = 1'b0;
        n  = 0;
        while (!ok && n < 20) begin
            @(posedge i_clock);
            n++;
            ok = (i_dtack_oe === 1'b1);
        end
        rd = i_bus;
        @(posedge i_clock);
        held = !ok || (i_dtack_oe === 1'b1);
        {o_as_n, o_ds0_n, o_ds1_n, o_lword_n, o_iack_n} <= 5'h1f;
        o_br_n <= 4'hf;
        o_data <= ~o_data;
        n = 0;
        // Idle long enough for the slave to see the release
        while ((n < 3 || i_dtack_oe !== 1'b0) && n < 10) begin
            @(posedge i_clock);
            n++;
        end
        held = held && (i_dtack_oe === 1'b0);
    endtask
endmodule

// ==== test_backplane_slave_signalling.sv ====
// Purpose: Self-checking bench for the backplane slave signalling block
// Assumes: Board selected except for one deselected write in t_lword; local read side answers one cycle late
// Notes:   Scenarios run back to back after one local reset
`timescale 1ns/1ns
module test_backplane_slave_signalling;
    logic        i_clock, i_rst_n, i_sysreset_n, i_board_sel, i_rd_valid, i_irq_req, i_fail_req, ext_fail;
    logic [15:0] i_rd_data, o_data, o_wr_data, bus, mdl_data, rd;
    logic [2:0]  i_irq_level, lvl;
    logic [7:0]  i_vector;
    logic [6:0]  o_irq_oe;
    logic [1:0]  o_wr_lanes;
    logic        as_n, ds0_n, ds1_n, wr_n, lw_n, iack_n, iackin_n, ok, held, saw_out;
    logic        o_data_oe, o_dtack_oe, o_iackout_n, o_sysfail_oe, o_rd_req, o_wr_strobe, o_fail_seen, o_in_reset;
    logic [3:0]  br_n;
    logic        sclk;
    int          n_mismatch, n_checks, n_wr, n_sclk;

    // Data wire: the slave wins while it drives
    assign bus = o_data_oe ? o_data : mdl_data;

    bss_master_model mdl_u (.i_clock(i_clock), .i_dtack_oe(o_dtack_oe), .i_bus(bus), .o_as_n(as_n),
        .o_ds0_n(ds0_n), .o_ds1_n(ds1_n), .o_write_n(wr_n), .o_lword_n(lw_n), .o_iack_n(iack_n),
        .o_iackin_n(iackin_n), .o_level(lvl), .o_br_n(br_n), .o_sysclk(sclk), .o_data(mdl_data));

    bss_top dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_as_n(as_n), .i_ds0_n(ds0_n), .i_ds1_n(ds1_n),
        .i_write_n(wr_n), .i_lword_n(lw_n), .i_iack_n(iack_n), .i_iackin_n(iackin_n),
        .i_sysreset_n(i_sysreset_n), .i_sysfail_n(~(o_sysfail_oe | ext_fail)), .i_ack_level(lvl),
        .i_data(bus), .o_data(o_data), .o_data_oe(o_data_oe), .o_dtack_oe(o_dtack_oe),
        .o_iackout_n(o_iackout_n), .o_irq_oe(o_irq_oe), .o_sysfail_oe(o_sysfail_oe),
        .i_board_sel(i_board_sel), .o_rd_req(o_rd_req), .i_rd_valid(i_rd_valid), .i_rd_data(i_rd_data),
        .o_wr_strobe(o_wr_strobe), .o_wr_data(o_wr_data), .o_wr_lanes(o_wr_lanes), .i_irq_req(i_irq_req),
        .i_irq_level(i_irq_level), .i_vector(i_vector), .i_fail_req(i_fail_req), .o_fail_seen(o_fail_seen),
        .o_in_reset(o_in_reset));

    // Clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // Local read side answers one cycle after the request; monitors
    always @(posedge i_clock) begin
        i_rd_valid <= o_rd_req;
        i_rd_data  <= 16'hc3a5;
        if (o_wr_strobe === 1'b1) n_wr++;
        if (o_iackout_n === 1'b0) saw_out <= 1'b1;
    end

    // System clock edge counter
    always @(posedge sclk) n_sclk++;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    // Word and byte writes, then a word read with held acknowledge
    task automatic t_data();
        mdl_u.xfer(1'b1, 2'b11, 1'b0, 1'b0, 3'h0, 16'h5a3c, rd, ok, held);
        chk({ok, held, n_wr[0]}, 3'h7);
        chk(o_wr_data, 16'h5a3c);
        chk(o_wr_lanes, 2'h3);
        mdl_u.xfer(1'b1, 2'b01, 1'b0, 1'b0, 3'h0, 16'h0081, rd, ok, held);
        chk({ok, held, o_wr_lanes}, 4'hd);
        mdl_u.xfer(1'b0, 2'b11, 1'b0, 1'b0, 3'h0, 16'h0000, rd, ok, held);
        chk({ok, held}, 2'h3);
        chk(rd, 16'hc3a5);
        chk(16'(n_wr), 16'h0002);
    endtask

    // A 32-bit cycle or a deselected board gets no answer; request and system clock
    task automatic t_lword();
        mdl_u.xfer(1'b1, 2'b11, 1'b1, 1'b0, 3'h0, 16'h1234, rd, ok, held);
        chk({ok, n_wr[1:0]}, 3'h2);
        i_board_sel <= 1'b0;
        mdl_u.xfer(1'b1, 2'b11, 1'b0, 1'b0, 3'h0, 16'h4321, rd, ok, held);
        chk({ok, n_wr[1:0]}, 3'h2);
        i_board_sel <= 1'b1;
        chk(br_n, 16'h000f);
        n_sclk = 0;
        wait_cyc(25);
        chk(16'(n_sclk), 16'h0004);
    endtask

    // Every level raised and acknowledged; wrong level passes down the chain
    task automatic t_irq();
        for (int k = 1; k <= 7; k++) begin
            @(posedge i_clock);
            i_irq_req   <= 1'b1;
            i_irq_level <= 3'(k);
            i_vector    <= 8'(8'h40 + k);
            @(posedge i_clock);
            i_irq_req <= 1'b0;
            wait_cyc(3);
            chk(o_irq_oe, 16'(7'h01 << (k - 1)));
            saw_out <= 1'b0;
            mdl_u.xfer(1'b0, 2'b01, 1'b0, 1'b1, 3'(k % 7 + 1), 16'h0000, rd, ok, held);
            chk({ok, saw_out}, 2'h1);
            mdl_u.xfer(1'b0, 2'b01, 1'b0, 1'b1, 3'(k), 16'h0000, rd, ok, held);
            chk({ok, rd[7:0]}, 16'(9'h140 + k));
            wait_cyc(2);
            chk(o_irq_oe, 16'h0000);
        end
    endtask

    // Fail line driven and seen; system reset holds the block
    task automatic t_fail_reset();
        @(posedge i_clock);
        i_fail_req <= 1'b1;
        wait_cyc(5);
        chk({o_sysfail_oe, o_fail_seen}, 2'h3);
        i_fail_req <= 1'b0;
        wait_cyc(5);
        chk({o_sysfail_oe, o_fail_seen}, 2'h0);
        ext_fail <= 1'b1;
        wait_cyc(5);
        chk(o_fail_seen, 1'b1);
        ext_fail     <= 1'b0;
        i_sysreset_n <= 1'b0;
        wait_cyc(5);
        chk({o_in_reset, o_dtack_oe, o_data_oe, o_irq_oe}, 16'h0200);
        i_sysreset_n <= 1'b1;
        wait_cyc(5);
        chk(o_in_reset, 1'b0);
        mdl_u.xfer(1'b1, 2'b10, 1'b0, 1'b0, 3'h0, 16'hbeef, rd, ok, held);
        chk(ok, 16'h0001);
        chk(o_wr_data, 16'hbeef);
    endtask

    // Watchdog
    initial begin
        #200000;
        n_mismatch++;
        close_out();
    end

    // Main sequence
    initial begin
        n_mismatch = 0;
        n_checks   = 0;
        n_wr       = 0;
        n_sclk     = 0;
        {i_rst_n, i_rd_valid, i_irq_req, i_fail_req, ext_fail, saw_out} = 6'h00;
        {i_sysreset_n, i_board_sel} = 2'h3;
        i_rd_data   = 16'h0000;
        i_irq_level = 3'h0;
        i_vector    = 8'h00;
        wait_cyc(2);
        chk({o_dtack_oe, o_data_oe, o_iackout_n, o_in_reset}, 4'h3);
        i_rst_n <= 1'b1;
        wait_cyc(3);
        t_data();
        t_lword();
        t_irq();
        t_fail_reset();
        close_out();
    end
endmodule
